// *** adcstc_top.sv ***
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - sequential mode, one sample clock per channel
// - simultaneous mode samples all, converts in turn
// - channel count selects one, two or four
// - samples per interrupt, one to sixteen
// - split buffer halves swap each interrupt
// - alternate input sets, first set first
// - scan channel zero over mask, low first
// - trigger ends sampling; code zero software clear
// - code seven triggers after auto-sample count
// - six further timer or external triggers
// - clearing converting bit aborts, buffer kept
// - converting-bit clear beats automatic sampling start
// - resume at next channel or next group
// - each conversion takes eleven converter clocks
// - converter clock is half-step divided instruction clock
// - RC select uses RC clock, divider ignored
// - completion stores result, flag at sample count
module adcstc_top #(
	parameter int RES_W = 10                   // result width
) (
	input  wire logic             clk_i,         // instruction clock
	input  wire logic             reset_i,       // sync reset, high
	input  wire logic [7:0]       paddr_i,       // apb address
	input  wire logic             psel_i,        // apb select
	input  wire logic             penable_i,     // apb enable
	input  wire logic             pwrite_i,      // apb direction
	input  wire logic [31:0]      pwdata_i,      // apb write data
	output logic      [31:0]      prdata_o,      // apb read data
	output logic                  pready_o,      // apb ready
	output logic                  pslverr_o,     // apb error
	input  wire logic             rc_clk_i,      // internal rc oscillator
	input  wire logic [5:0]       ext_trig_i,    // timer/external triggers
	input  wire logic [RES_W-1:0] result_i,      // sar core result
	output logic      [3:0]       sample_hold_o, // sample/hold enables
	output logic      [3:0]       ch0_input_o,   // channel zero input
	output logic                  input_set_o,   // 0 first set, 1 second
	output logic                  converting_bit_start_o,  // conversion start pulse
	output logic      [1:0]       converting_bit_chan_o,   // channel being converted
	output logic                  converting_bit_abort_o,  // abort pulse
	output logic                  irq_flag_o     // conversion flag level
);
	adcstc_pkg::adcstc_state_type state, next_state;
	logic [6:0]       sync1, sync2, sync3;
	logic             module_on, simul, auto_start, scan_en, split, alternate_input_sel, rc_sel, irq_flag;
	logic [2:0]       trig_sel;
	logic [1:0]       channel_count_sel, chan;
	logic [3:0]       samples_per_irq, in_a, in_b, wr_ptr, sampling_bit_cnt, scan_idx;
	logic [4:0]       auto_sample_count, tad_cnt;
	logic [5:0]       div;
	logic [6:0]       tad_acc;
	logic [15:0]      scan_mask;
	logic             half, alt_b;
	logic [31:0]      rd_mux;
	logic [RES_W-1:0] result_buffer [adcstc_pkg::BUF_DEPTH];

	// lowest mask bit at or above the start, else wrap to lowest
	function automatic logic [3:0] adcstc_first(input logic [15:0] m, input logic [3:0] from);
		logic [3:0] lo;
		logic [3:0] hi;
		logic       fh;
		lo = 4'h0;
		hi = 4'h0;
		fh = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			if (m[i]) begin
				lo = 4'(i);
				if (4'(i) >= from) begin
					hi = 4'(i);
					fh = 1'b1;
				end
			end
		end
		return fh ? hi : lo;
	endfunction : adcstc_first

	// pins from other domains: two flops, third only for edge detect
	always_ff @(posedge clk_i) begin
		sync1 <= {ext_trig_i, rc_clk_i};
		sync2 <= sync1;
		sync3 <= sync2;
	end
	wire       rc_tick   = sync2[0] & ~sync3[0];
	wire [5:0] trig_rise = sync2[6:1] & ~sync3[6:1];

	// apb decode: zero wait states, unmapped word answers with error
	wire setup   = psel_i & ~penable_i;
	wire access  = psel_i & penable_i;
	wire wr      = access & pwrite_i;
	wire h_c1    = paddr_i == adcstc_pkg::CTRL1_OFF;
	wire h_c2    = paddr_i == adcstc_pkg::CTRL2_OFF;
	wire h_c3    = paddr_i == adcstc_pkg::CTRL3_OFF;
	wire h_in    = paddr_i == adcstc_pkg::INSEL_OFF;
	wire h_scan  = paddr_i == adcstc_pkg::SCAN_OFF;
	wire h_stat  = paddr_i == adcstc_pkg::STAT_OFF;
	wire h_buf   = (paddr_i[7:6] == adcstc_pkg::BUF_PAGE) & (paddr_i[1:0] == 2'h0);
	wire mapped  = h_c1 | h_c2 | h_c3 | h_in | h_scan | h_stat | h_buf;
	wire [3:0] buf_idx = paddr_i[5:2];
	assign pready_o  = 1'b1;
	assign pslverr_o = access & ~mapped;

	// software events on the sampling and converting bits
	wire w_c1        = wr & h_c1;
	wire sw_sampling_bit_set = w_c1 & pwdata_i[adcstc_pkg::SAMPLING_BIT_BIT];
	wire sw_sampling_bit_clr = w_c1 & ~pwdata_i[adcstc_pkg::SAMPLING_BIT_BIT];
	wire sw_converting_bit_clr = w_c1 & ~pwdata_i[adcstc_pkg::CONVERTING_BIT_BIT];

	// converter clock: half-cycle accumulator, at most one tick per clock
	wire [6:0] tad_len  = {1'b0, div} + 7'h01;
	wire [6:0] acc_step = tad_acc + 7'h02;
	wire       clk_tick = acc_step >= tad_len;
	wire       tad_tick = rc_sel ? rc_tick : clk_tick;
	always_ff @(posedge clk_i) begin
		if (reset_i | rc_sel | ~module_on | (tad_len == 7'h01))
			tad_acc <= 7'h00;
		else
			tad_acc <= clk_tick ? acc_step - tad_len : acc_step;
	end

	// sequence decode
	wire [1:0] last_ch  = (channel_count_sel == 2'h0) ? 2'h0 : (channel_count_sel == 2'h1) ? 2'h1 : 2'h3;
	wire [3:0] sel_mask = (channel_count_sel == 2'h0) ? 4'h1 : (channel_count_sel == 2'h1) ? 4'h3 : 4'hF;
	wire in_sampling_bit   = state == adcstc_pkg::ST_SAMPLE;
	wire in_converting_bit   = state == adcstc_pkg::ST_CONVERTING_BIT;
	wire ext_code  = (trig_sel != adcstc_pkg::TRIG_SW) & (trig_sel != adcstc_pkg::TRIG_AUTO);
	wire trig_sw   = (trig_sel == adcstc_pkg::TRIG_SW) & sw_sampling_bit_clr;
	wire trig_auto = (trig_sel == adcstc_pkg::TRIG_AUTO) & tad_tick & (tad_cnt + 5'h01 >= auto_sample_count);
	wire trig_ext  = ext_code & trig_rise[trig_sel - 3'h1];
	wire trigger   = in_sampling_bit & module_on & (trig_sw | trig_auto | trig_ext);
	wire abort     = in_converting_bit & sw_converting_bit_clr;
	wire converting_bit_done = in_converting_bit & ~abort & tad_tick & (tad_cnt == adcstc_pkg::CONVERTING_BIT_TADS - 5'h01);
	wire grp_more  = simul & (chan != last_ch);
	wire sampling_bit_end  = converting_bit_done & ~grp_more;                    // one sample clock finished
	wire seq_end   = sampling_bit_end & (simul | (chan == last_ch));
	wire irq_event = sampling_bit_end & (sampling_bit_cnt == samples_per_irq);
	wire [3:0] scan_pick = adcstc_first(scan_mask, scan_idx);
	wire [3:0] wr_addr   = split ? {half, wr_ptr[2:0]} : wr_ptr;

	// state transitions; a clear of the converting bit stops auto restart
	always_comb begin
		next_state = state;
		case (state)
			adcstc_pkg::ST_IDLE: begin
				if (sw_sampling_bit_set & pwdata_i[adcstc_pkg::ON_BIT])   // turn-on write may start sampling too
					next_state = adcstc_pkg::ST_SAMPLE;
			end
			adcstc_pkg::ST_SAMPLE: begin
				if (~module_on | (sw_sampling_bit_clr & ~trigger))
					next_state = adcstc_pkg::ST_IDLE;
				else if (trigger)
					next_state = adcstc_pkg::ST_CONVERTING_BIT;
			end
			adcstc_pkg::ST_CONVERTING_BIT: begin
				if (~module_on | abort)
					next_state = adcstc_pkg::ST_IDLE;
				else if (sampling_bit_end)
					next_state = auto_start ? adcstc_pkg::ST_SAMPLE : adcstc_pkg::ST_IDLE;
			end
			default: next_state = adcstc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			state <= adcstc_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	// converter clock counter for sample time and conversion length
	always_ff @(posedge clk_i) begin
		if (reset_i | (next_state != state) | trigger | converting_bit_done)
			tad_cnt <= 5'h00;
		else if (tad_tick & (tad_cnt != 5'h1F))
			tad_cnt <= tad_cnt + 5'h01;
	end

	// channel pointer: sequential steps per sample, group restarts at zero
	always_ff @(posedge clk_i) begin
		if (reset_i | ~module_on)
			chan <= 2'h0;
		else if (trigger & simul)
			chan <= 2'h0;
		else if (converting_bit_done & grp_more)
			chan <= chan + 2'h1;
		else if (converting_bit_done | (abort & ~simul))
			chan <= (chan == last_ch) ? 2'h0 : chan + 2'h1;
		else if (abort)
			chan <= 2'h0;
	end

	// sample counting, buffer pointer and half swap per interrupt
	always_ff @(posedge clk_i) begin
		if (reset_i | ~module_on) begin
			sampling_bit_cnt <= 4'h0;
			wr_ptr   <= 4'h0;
			half     <= 1'b0;
		end else if (irq_event) begin
			sampling_bit_cnt <= 4'h0;
			wr_ptr   <= 4'h0;
			half     <= split ? ~half : 1'b0;
		end else begin
			if (sampling_bit_end)
				sampling_bit_cnt <= sampling_bit_cnt + 4'h1;
			if (converting_bit_done)
				wr_ptr <= wr_ptr + 4'h1;
		end
	end

	// input set alternation and channel zero scan position
	always_ff @(posedge clk_i) begin
		if (reset_i | ~module_on | ~alternate_input_sel)
			alt_b <= 1'b0;
		else if (seq_end)
			alt_b <= ~alt_b;
		if (reset_i | ~module_on | irq_event)
			scan_idx <= 4'h0;
		else if (converting_bit_done & scan_en & ~alt_b & (chan == 2'h0))
			scan_idx <= scan_pick + 4'h1;
	end

	// result store: no reset, aborted conversions never write
	always_ff @(posedge clk_i) begin
		if (wr & h_buf)
			result_buffer[buf_idx] <= pwdata_i[RES_W-1:0];
		if (converting_bit_done)
			result_buffer[wr_addr] <= result_i;
	end

	// flag: the hardware set wins over a write-one clear
	always_ff @(posedge clk_i) begin
		if (reset_i)
			irq_flag <= 1'b0;
		else
			irq_flag <= irq_event | (irq_flag & ~(wr & h_stat & pwdata_i[adcstc_pkg::IRQ_BIT]));
	end

	// control registers; settings are expected steady while the module runs
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			{module_on, trig_sel, simul, auto_start} <= adcstc_pkg::CTRL_RESET[5:0];
			{scan_en, channel_count_sel, samples_per_irq, split, alternate_input_sel}       <= adcstc_pkg::CTRL_RESET[8:0];
			{auto_sample_count, rc_sel, div}                      <= adcstc_pkg::CTRL_RESET[11:0];
			{in_a, in_b}                             <= adcstc_pkg::CTRL_RESET[7:0];
			scan_mask                                <= adcstc_pkg::CTRL_RESET[15:0];
		end else if (wr) begin
			if (h_c1) begin
				module_on  <= pwdata_i[adcstc_pkg::ON_BIT];
				trig_sel   <= pwdata_i[adcstc_pkg::TRIG_LSB +: 3];
				simul      <= pwdata_i[adcstc_pkg::SIMUL_BIT];
				auto_start <= pwdata_i[adcstc_pkg::ASTRT_BIT];
			end
			if (h_c2) begin
				scan_en <= pwdata_i[adcstc_pkg::SCAN_BIT];
				channel_count_sel    <= pwdata_i[adcstc_pkg::CHANNEL_COUNT_SEL_LSB +: 2];
				samples_per_irq    <= pwdata_i[adcstc_pkg::SAMPLES_PER_IRQ_LSB +: 4];
				split   <= pwdata_i[adcstc_pkg::SPLIT_BIT];
				alternate_input_sel    <= pwdata_i[adcstc_pkg::ALTERNATE_INPUT_SEL_BIT];
			end
			if (h_c3) begin
				auto_sample_count   <= pwdata_i[adcstc_pkg::AUTO_SAMPLE_COUNT_LSB +: 5];
				rc_sel <= pwdata_i[adcstc_pkg::RC_BIT];
				div    <= pwdata_i[adcstc_pkg::DIV_LSB +: 6];
			end
			if (h_in) begin
				in_a <= pwdata_i[adcstc_pkg::INA_LSB +: 4];
				in_b <= pwdata_i[adcstc_pkg::INB_LSB +: 4];
			end
			if (h_scan)
				scan_mask <= pwdata_i[15:0];
		end
	end

	// read mux; sampling and converting bits mirror the sequencer state
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (h_c1) begin
			rd_mux[adcstc_pkg::ON_BIT]          = module_on;
			rd_mux[adcstc_pkg::TRIG_LSB +: 3]   = trig_sel;
			rd_mux[adcstc_pkg::SIMUL_BIT]       = simul;
			rd_mux[adcstc_pkg::ASTRT_BIT]       = auto_start;
			rd_mux[adcstc_pkg::SAMPLING_BIT_BIT]        = in_sampling_bit;
			rd_mux[adcstc_pkg::CONVERTING_BIT_BIT]        = in_converting_bit;
		end else if (h_c2) begin
			rd_mux[adcstc_pkg::SCAN_BIT]        = scan_en;
			rd_mux[adcstc_pkg::CHANNEL_COUNT_SEL_LSB +: 2]   = channel_count_sel;
			rd_mux[adcstc_pkg::SAMPLES_PER_IRQ_LSB +: 4]   = samples_per_irq;
			rd_mux[adcstc_pkg::SPLIT_BIT]       = split;
			rd_mux[adcstc_pkg::ALTERNATE_INPUT_SEL_BIT]        = alternate_input_sel;
		end else if (h_c3) begin
			rd_mux[adcstc_pkg::AUTO_SAMPLE_COUNT_LSB +: 5]   = auto_sample_count;
			rd_mux[adcstc_pkg::RC_BIT]          = rc_sel;
			rd_mux[adcstc_pkg::DIV_LSB +: 6]    = div;
		end else if (h_in) begin
			rd_mux[adcstc_pkg::INA_LSB +: 4]    = in_a;
			rd_mux[adcstc_pkg::INB_LSB +: 4]    = in_b;
		end else if (h_scan) begin
			rd_mux[15:0]                        = scan_mask;
		end else if (h_stat) begin
			rd_mux[adcstc_pkg::IRQ_BIT]         = irq_flag;
			rd_mux[adcstc_pkg::HALF_BIT]        = half;
			rd_mux[adcstc_pkg::PTR_LSB +: 4]    = wr_addr;
			rd_mux[adcstc_pkg::SCNT_LSB +: 4]   = sampling_bit_cnt;
			rd_mux[adcstc_pkg::CHAN_LSB +: 2]   = chan;
			rd_mux[adcstc_pkg::ALTB_BIT]        = alt_b;
		end else if (h_buf) begin
			rd_mux[RES_W-1:0]                   = result_buffer[buf_idx];
		end
	end

	// read data captured in the setup cycle, held through the access cycle
	always_ff @(posedge clk_i) begin
		if (reset_i)
			prdata_o <= 32'h0000_0000;
		else if (setup)
			prdata_o <= rd_mux;
	end

	// converter core strobes, registered so they are glitch free
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			converting_bit_start_o <= 1'b0;
			converting_bit_abort_o <= 1'b0;
		end else begin
			converting_bit_start_o <= trigger | (converting_bit_done & grp_more);
			converting_bit_abort_o <= abort | (in_converting_bit & ~module_on);
		end
	end

	// analog side: sample enables and input routing decoded from state flops
	assign sample_hold_o = in_sampling_bit ? (simul ? sel_mask : (4'h1 << chan)) : 4'h0;
	assign ch0_input_o   = alt_b ? in_b : (scan_en ? scan_pick : in_a);
	assign input_set_o   = alt_b;
	assign converting_bit_chan_o   = chan;
	assign irq_flag_o    = irq_flag;
endmodule : adcstc_top
`default_nettype wire

// *** adcstc_pkg.sv ***
`default_nettype none
package adcstc_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL1_OFF = 8'h00;
	localparam logic [7:0] CTRL2_OFF = 8'h04;
	localparam logic [7:0] CTRL3_OFF = 8'h08;
	localparam logic [7:0] INSEL_OFF = 8'h0C;
	localparam logic [7:0] SCAN_OFF  = 8'h10;
	localparam logic [7:0] STAT_OFF  = 8'h14;
	localparam logic [1:0] BUF_PAGE  = 2'h1;   // paddr[7:6], words 0x40..0x7C
	// first control word
	localparam int ON_BIT    = 15;
	localparam int TRIG_LSB  = 5;
	localparam int SIMUL_BIT = 3;
	localparam int ASTRT_BIT = 2;
	localparam int SAMPLING_BIT_BIT  = 1;
	localparam int CONVERTING_BIT_BIT  = 0;
	// second control word
	localparam int SCAN_BIT  = 10;
	localparam int CHANNEL_COUNT_SEL_LSB  = 8;
	localparam int SAMPLES_PER_IRQ_LSB  = 2;
	localparam int SPLIT_BIT = 1;
	localparam int ALTERNATE_INPUT_SEL_BIT  = 0;
	// third control word
	localparam int AUTO_SAMPLE_COUNT_LSB  = 8;
	localparam int RC_BIT    = 7;
	localparam int DIV_LSB   = 0;
	// input select and status
	localparam int INA_LSB   = 0;
	localparam int INB_LSB   = 8;
	localparam int IRQ_BIT   = 0;
	localparam int HALF_BIT  = 1;
	localparam int PTR_LSB   = 4;
	localparam int SCNT_LSB  = 8;
	localparam int CHAN_LSB  = 12;
	localparam int ALTB_BIT  = 14;
	// reset values
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// trigger codes and timing
	localparam logic [2:0] TRIG_SW   = 3'h0;
	localparam logic [2:0] TRIG_AUTO = 3'h7;
	localparam logic [4:0] CONVERTING_BIT_TADS = 5'h0B;  // converter clocks per conversion
	localparam int BUF_DEPTH = 16;
	typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERTING_BIT} adcstc_state_type;
endpackage : adcstc_pkg
`default_nettype wire

// *** adcstc_sar_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// converter core stand-in: each result tags start order and channel
module adcstc_sar_model (
	input  wire logic       clk_i,   // clock
	input  wire logic       reset_i, // sync reset
	input  wire logic       start_i, // conversion start
	input  wire logic [1:0] chan_i,  // channel converted
	output logic      [9:0] result_o // result to block
);
	logic [3:0] seq;
	// fresh code per start so a stale word never passes for a new one
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			seq      <= 4'h0;
			result_o <= 10'h2AA;
		end else if (start_i) begin
			seq      <= seq + 4'h1;
			result_o <= {seq, 4'h0, chan_i};
		end
	end
endmodule : adcstc_sar_model
`default_nettype wire

// *** adcstc_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcstc_chk (
	input wire logic        clk_i,         // clock
	input wire logic        reset_i,       // sync reset
	input wire logic [7:0]  paddr_i,       // address
	input wire logic        psel_i,        // select
	input wire logic        penable_i,     // enable
	input wire logic        pwrite_i,      // direction
	input wire logic [31:0] pwdata_i,      // write data
	input wire logic [3:0]  sample_hold_o, // hold enables
	input wire logic [3:0]  ch0_input_o,   // input pick
	input wire logic        converting_bit_start_o,  // start pulse
	input wire logic [1:0]  converting_bit_chan_o,   // channel
	input wire logic        converting_bit_abort_o,  // abort pulse
	input wire logic        irq_flag_o     // flag
);
	logic [4:0] gap;
	// cycles since last start; an abort reopens the window
	always_ff @(posedge clk_i) begin
		if (reset_i || converting_bit_abort_o)
			gap <= 5'h1F;
		else if (converting_bit_start_o)
			gap <= 5'h00;
		else if (gap != 5'h1F)
			gap <= gap + 5'h01;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_hold_shape: assert property (sample_hold_o inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hF})
		else $error("hold pattern illegal");
	a_seq_onehot: assert property ($onehot(sample_hold_o) |-> sample_hold_o == 4'h1 << converting_bit_chan_o)
		else $error("hold channel mismatch");
	a_group_base: assert property (sample_hold_o inside {4'h3, 4'hF} |-> converting_bit_chan_o == 2'h0)
		else $error("group not at channel zero");
	a_hold_ends: assert property (converting_bit_start_o |-> sample_hold_o == 4'h0)
		else $error("sampling during start");
	a_converting_bit_gap: assert property (converting_bit_start_o |-> gap >= 5'h09)
		else $error("conversion too short");
	a_flag_late: assert property ($rose(irq_flag_o) |-> gap >= 5'h09)
		else $error("flag before conversion end");
	a_abort_halts: assert property (converting_bit_abort_o |=> !converting_bit_start_o && sample_hold_o == 4'h0 ##1 !converting_bit_start_o)
		else $error("sequencing after abort");
	a_ch0_steady: assert property (sample_hold_o[0] && $past(sample_hold_o[0]) |-> $stable(ch0_input_o))
		else $error("input pick moved");
	a_flag_clear: assert property ($fell(irq_flag_o) |-> $past(psel_i && penable_i && pwrite_i && pwdata_i[0] && paddr_i == 8'h14))
		else $error("flag fell without clear");
endmodule : adcstc_chk
bind adcstc_top adcstc_chk adcstc_chk_i (.clk_i(clk_i), .reset_i(reset_i), .paddr_i(paddr_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .sample_hold_o(sample_hold_o),
	.ch0_input_o(ch0_input_o), .converting_bit_start_o(converting_bit_start_o), .converting_bit_chan_o(converting_bit_chan_o),
	.converting_bit_abort_o(converting_bit_abort_o), .irq_flag_o(irq_flag_o));
`default_nettype wire

// *** adc_sequence_trigger_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module adc_sequence_trigger_control_tb;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        rc_clk_i = 1'b0;
	logic [7:0]  paddr_i = 8'h00;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [31:0] pwdata_i = 32'h0;
	logic [5:0]  ext_trig_i = 6'h00;
	logic        hold_d = 1'b0;
	logic [31:0] prdata_o, rd;
	logic [9:0]  result_i;
	logic [3:0]  sample_hold_o, ch0_input_o;
	logic [1:0]  converting_bit_chan_o;
	logic        pready_o, pslverr_o, input_set_o, converting_bit_start_o, converting_bit_abort_o, irq_flag_o, err;
	logic [1:0]  chans[$];
	logic [8:0]  holds[$];
	int          fails = 0, samples_checked = 0, n_start = 0, n_abort = 0, waited;

	// rc oscillator runs free, unrelated to the core clock
	always #2 clk_i = ~clk_i;
	always #10.3 rc_clk_i = ~rc_clk_i;

	adcstc_top adcstc_top_i (.clk_i(clk_i), .reset_i(reset_i), .paddr_i(paddr_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .rc_clk_i(rc_clk_i), .ext_trig_i(ext_trig_i),
		.result_i(result_i), .sample_hold_o(sample_hold_o), .ch0_input_o(ch0_input_o),
		.input_set_o(input_set_o), .converting_bit_start_o(converting_bit_start_o), .converting_bit_chan_o(converting_bit_chan_o),
		.converting_bit_abort_o(converting_bit_abort_o), .irq_flag_o(irq_flag_o));
	adcstc_sar_model adcstc_sar_model_i (.clk_i(clk_i), .reset_i(reset_i), .start_i(converting_bit_start_o),
		.chan_i(converting_bit_chan_o), .result_o(result_i));

	// log starts, aborts and each fresh sampling window
	always @(posedge clk_i) begin
		hold_d <= |sample_hold_o;
		if (converting_bit_start_o) begin
			chans.push_back(converting_bit_chan_o);
			n_start++;
		end
		if (converting_bit_abort_o)
			n_abort++;
		if (|sample_hold_o && !hold_d)
			holds.push_back({sample_hold_o, ch0_input_o, input_set_o});
	end

	task automatic finish_test();
		$display("compares %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	// one transfer; request held until pready is seen high
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 16);
		rd = prdata_o;
		err = pslverr_o;
		{psel_i, penable_i} <= 2'b00;
		if (n >= 16) begin
			fails++;
			finish_test();
		end
	endtask : apb

	// bounded wait for a start pulse or the flag, looked at mid-cycle
	task automatic wait_for(input logic on_flag, input int lim);
		waited = 0;
		do begin
			@(negedge clk_i);
			waited++;
		end while ((on_flag ? irq_flag_o : converting_bit_start_o) !== 1'b1 && waited < lim);
		if (waited >= lim) begin
			fails++;
			finish_test();
		end
	endtask : wait_for

	// reset value and an unmapped read
	task automatic t_reset();
		apb(8'h04, 1'b0, 32'h0);
		`CHECK(rd, 32'h0)
		apb(8'h1A, 1'b0, 32'h0);
		`CHECK({err, rd}, 33'h1_0000_0000)
	endtask : t_reset

	// four channels in turn, four samples per flag
	task automatic t_seq();
		int b;
		b = n_start;
		chans.delete();
		apb(8'h08, 1'b1, 32'h100); // one tick of sampling
		apb(8'h04, 1'b1, 32'h20C); // four channels, four samples per flag
		apb(8'h00, 1'b1, 32'h80E6);
		wait_for(1'b1, 300);
		`CHECK(n_start - b, 4)
		apb(8'h00, 1'b1, 32'h0);
		apb(8'h14, 1'b1, 32'h1);
		for (int k = 0; k < 4; k++) begin
			`CHECK(chans[k], 2'(k))
			apb(8'h40 + 8'(4 * k), 1'b0, 32'h0);
			`CHECK(rd[9:0], {4'(b + k), 4'h0, 2'(k)})
		end
	endtask : t_seq

	// simultaneous pair, split buffer, alternating sets
	task automatic t_split();
		int b;
		b = n_start;
		holds.delete();
		apb(8'h0C, 1'b1, 32'h903);
		apb(8'h04, 1'b1, 32'h103); // settings only while off
		apb(8'h00, 1'b1, 32'h80EE);
		wait_for(1'b1, 200);
		apb(8'h14, 1'b1, 32'h1);
		wait_for(1'b1, 200);
		apb(8'h00, 1'b1, 32'h0);
		apb(8'h14, 1'b1, 32'h1);
		`CHECK(holds[0], {4'h3, 4'h3, 1'b0})
		`CHECK(holds[1], {4'h3, 4'h9, 1'b1})
		for (int k = 0; k < 4; k++) begin
			apb(8'h40 + 8'(k[1] * 32 + k[0] * 4), 1'b0, 32'h0);
			`CHECK(rd[9:0], {4'(b + k), 5'h00, k[0]})
		end
	endtask : t_split

	// channel zero walks the mask, top input unreached, restarts after the flag
	task automatic t_scan();
		holds.delete();
		apb(8'h10, 1'b1, 32'h1224);
		apb(8'h04, 1'b1, 32'h408);
		apb(8'h00, 1'b1, 32'h80E6);
		wait_for(1'b1, 200);
		apb(8'h00, 1'b1, 32'h0);
		apb(8'h14, 1'b1, 32'h1);
		`CHECK(holds[0], {4'h1, 4'h2, 1'b0})
		`CHECK(holds[1], {4'h1, 4'h5, 1'b0})
		`CHECK(holds[2], {4'h1, 4'h9, 1'b0})
		`CHECK(holds[3], {4'h1, 4'h2, 1'b0})
	endtask : t_scan

	// abort a slow conversion; old word must survive
	task automatic t_abort();
		int a;
		a = n_abort;
		apb(8'h04, 1'b1, 32'h0);
		apb(8'h08, 1'b1, 32'h13F); // slowest divider this clock allows
		apb(8'h40, 1'b1, 32'h155);
		apb(8'h00, 1'b1, 32'h8002);
		apb(8'h00, 1'b1, 32'h8000);
		apb(8'h00, 1'b0, 32'h0);
		`CHECK(rd[1:0], 2'b01)
		apb(8'h00, 1'b1, 32'h8000);
		repeat (400) @(posedge clk_i); // longer than a whole slow conversion
		`CHECK(n_abort - a, 1)
		apb(8'h40, 1'b0, 32'h0);
		`CHECK(rd[9:0], 10'h155)
		`CHECK(irq_flag_o, 1'b0)
	endtask : t_abort

	// eleven ticks of (div+1)/2 clocks but at least one clock, or of the rc clock
	task automatic t_timing();
		logic [31:0] cfg[3] = '{32'h100, 32'h107, 32'h1BF};
		int lo[3] = '{10, 40, 48};
		int hi[3] = '{13, 48, 66};
		for (int k = 0; k < 3; k++) begin
			apb(8'h00, 1'b1, 32'h0);
			apb(8'h08, 1'b1, cfg[k]);
			apb(8'h00, 1'b1, 32'h80E2); // auto trigger
			wait_for(1'b0, 40);
			wait_for(1'b1, 100);
			`CHECK(waited inside {[lo[k]:hi[k]]}, 1'b1)
			apb(8'h14, 1'b1, 32'h1);
		end
	endtask : t_timing

	// each pin trigger code starts a conversion
	task automatic t_ext();
		for (int c = 1; c < 7; c++) begin
			apb(8'h00, 1'b1, 32'h0);
			apb(8'h00, 1'b1, 32'h8002 | 32'(c << 5));
			ext_trig_i <= 6'(1 << (c - 1));
			wait_for(1'b0, 12);
			`CHECK(converting_bit_chan_o, 2'h0)
			@(posedge clk_i);
			ext_trig_i <= 6'h00;
		end
	endtask : t_ext

	initial begin
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b0;
		t_reset();
		t_seq();
		t_split();
		t_scan();
		t_abort();
		t_timing();
		t_ext();
		finish_test();
	end
endmodule : adc_sequence_trigger_control_tb
`default_nettype wire
